// ==== hw/mcu_reset_controller.sv ====
// reset generation and reset-cause tracking for a small microcontroller
// Behaviour
// - power-on reset clears program counter to zero
// - power-on reset sets port data and direction registers to all ones
// - hold reset for a 50 ms power-on delay after power up
// - undervoltage reset enabled except in power-down mode; resets core and sets undervoltage flag
// - low-supply indication resets only if longer than minimum duration
// - threshold field decodes four codes: 55, 33, 99, AA hex
// - invalid threshold code resets after 2 to 3 slow oscillator cycles
// - invalid code reset restores threshold register to power-on value
// - genuine low-voltage reset keeps threshold register contents
// - threshold register resets to 55 hex at power-on
// - threshold-code flag set while threshold register holds undefined code
// - reset flags set only by hardware; software write 0 clears; status bits take the written value
// - undervoltage reset disabled in power-down mode
// - watchdog time-out in normal mode: full reset, expiry flag set
// - watchdog time-out in sleep/idle: clear PC and SP only, flag set
// - status flags per reset type: POR clears, watchdog sets as tabled
// - all interrupts disabled after power-on reset
// - watchdog and time base cleared after POR, watchdog counts at once
// - timer counters off after power-on reset
// - ports inputs and analog channels 0 to 7 selected after POR
// - stack pointer points to top of stack after POR
// - settle time 16 fast, 128 crystal, 2 slow oscillator cycles
// - invalid watchdog code resets after 2 to 3 slow cycles, sets flag
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
module mcu_reset_controller
  import rstc_pkg::*;
#(
  parameter int POR_CYC = POR_DELAY_CYC,
  parameter int UV_MIN_CYC = 64
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // avalon-mm slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // events from the system
  input wire logic i_low_supply,
  input wire logic i_slow_osc,
  input wire logic i_wdt_timeout,
  input wire logic i_sleep_mode,
  input wire logic i_powerdown,
  input wire logic [1:0] i_clk_src,
  // reset outputs
  output logic o_full_rst,
  output logic o_pc_sp_rst,
  output logic o_por_state,
  output logic [7:0] o_level_sel,
  output logic o_wdt_on
);

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b11,
    ST_HOLD = 2'b10
  } state_type;

  function automatic logic valid_level(input logic [7:0] code);
    valid_level = (code == LVL_2V10) || (code == LVL_2V55) ||
                  (code == LVL_3V15) || (code == LVL_3V80);
  endfunction

  state_type state_reg, state_next;
  logic [31:0] count_reg;
  logic [7:0] level_reg;
  logic [4:0] wdt_code_reg;
  logic uv_flag_reg, lvl_flag_reg, wdc_flag_reg, idle_keep_reg;
  logic expiry_reg, pdown_reg;
  logic [2:0] lsup_sync_reg, slow_sync_reg;
  logic [15:0] uv_cnt_reg;
  logic [1:0] lvl_edge_reg, wdc_edge_reg;
  logic full_rst_reg, pc_sp_rst_reg, wait_reg, wdt_on_reg, por_reg;
  logic [31:0] rdata_reg;

  // synchronised pins: change counts once stages 2 and 3 agree
  logic lsup_q, slow_q, slow_rise;
  logic lsup_agree, slow_agree;
  assign lsup_agree = lsup_sync_reg[1] == lsup_sync_reg[2];
  assign slow_agree = slow_sync_reg[1] == slow_sync_reg[2];
  logic lsup_hold_reg, slow_hold_reg, slow_prev_reg;
  assign lsup_q = lsup_agree ? lsup_sync_reg[2] : lsup_hold_reg;
  assign slow_q = slow_agree ? slow_sync_reg[2] : slow_hold_reg;
  assign slow_rise = slow_q && !slow_prev_reg;

  // bus decode: an access completes at the edge where wait_reg is low
  logic bus_req, rd_take;
  logic wr_level, wr_cause, wr_status, wr_wdt;
  assign bus_req = i_read || i_write;
  assign rd_take = i_read && wait_reg;
  assign wr_level = i_write && !wait_reg && i_address == ADDR_LEVEL_SEL;
  assign wr_cause = i_write && !wait_reg && i_address == ADDR_CAUSE;
  assign wr_status = i_write && !wait_reg && i_address == ADDR_STATUS;
  assign wr_wdt = i_write && !wait_reg && i_address == ADDR_WDT_EN;

  // event decode
  logic running, level_bad, wdc_bad, uv_fire, lvl_fire, wdc_fire, wdt_full, wdt_part;
  assign running = state_reg == ST_RUN;
  assign level_bad = !valid_level(level_reg);
  assign wdc_bad = wdt_code_reg != WDT_CODE_ON && wdt_code_reg != WDT_CODE_OFF;
  assign uv_fire = running && !i_powerdown && uv_cnt_reg == 16'(UV_MIN_CYC);
  assign lvl_fire = running && level_bad && lvl_edge_reg == 2'(BAD_CODE_SLOW_CYC)
                    && slow_rise;
  assign wdc_fire = running && wdc_bad && wdc_edge_reg == 2'(BAD_CODE_SLOW_CYC)
                    && slow_rise;
  assign wdt_full = running && i_wdt_timeout && !i_sleep_mode;
  assign wdt_part = running && i_wdt_timeout && i_sleep_mode;

  logic any_full;
  assign any_full = uv_fire || lvl_fire || wdc_fire || wdt_full;

  logic [31:0] settle_cyc;
  assign settle_cyc = (i_clk_src == SRC_XTAL) ? 32'(SETTLE_XTAL_CYC) :
                      (i_clk_src == SRC_SLOW) ? 32'(SETTLE_SLOW_CYC) :
                      32'(SETTLE_FAST_CYC);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POR: if (count_reg >= 32'(POR_CYC) - 32'h1) state_next = ST_SETTLE;
      ST_SETTLE: if (count_reg >= settle_cyc - 32'h1) state_next = ST_RUN;
      ST_RUN: if (any_full) state_next = ST_HOLD;
      ST_HOLD: state_next = ST_SETTLE;
    endcase
  end

  logic [31:0] rd_mux;
  assign rd_mux = (i_address == ADDR_LEVEL_SEL) ? {24'h0, level_reg} :
                  (i_address == ADDR_CAUSE) ?
                    {24'h0, idle_keep_reg, 4'h0, uv_flag_reg, lvl_flag_reg, wdc_flag_reg} :
                  (i_address == ADDR_STATUS) ? {30'h0, expiry_reg, pdown_reg} :
                  (i_address == ADDR_WDT_EN) ? {27'h0, wdt_code_reg} : 32'h0;

  // state and delay counter
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_reg <= ST_POR;
      count_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      count_reg <= (state_next != state_reg) ? 32'h0 : count_reg + 32'h1;
    end
  end

  // three-flop pin synchronisers and held agreed values
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      lsup_sync_reg <= 3'h0;
      slow_sync_reg <= 3'h0;
      lsup_hold_reg <= 1'b0;
      slow_hold_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
    end else begin
      lsup_sync_reg <= {lsup_sync_reg[1:0], i_low_supply};
      slow_sync_reg <= {slow_sync_reg[1:0], i_slow_osc};
      lsup_hold_reg <= lsup_q;
      slow_hold_reg <= slow_q;
      slow_prev_reg <= slow_q;
    end
  end

  // low supply must persist; ignored in power-down
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      uv_cnt_reg <= 16'h0;
    end else if (lsup_q && running && !i_powerdown && uv_cnt_reg != 16'(UV_MIN_CYC)) begin
      uv_cnt_reg <= uv_cnt_reg + 16'h1;
    end else if (!lsup_q || i_powerdown || !running) begin
      uv_cnt_reg <= 16'h0;
    end
  end

  // slow-clock edge counters for bad codes
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      lvl_edge_reg <= 2'h0;
      wdc_edge_reg <= 2'h0;
    end else begin
      if (!level_bad || !running) begin
        lvl_edge_reg <= 2'h0;
      end else if (slow_rise && lvl_edge_reg != 2'(BAD_CODE_SLOW_CYC)) begin
        lvl_edge_reg <= lvl_edge_reg + 2'h1;
      end
      if (!wdc_bad || !running) begin
        wdc_edge_reg <= 2'h0;
      end else if (slow_rise && wdc_edge_reg != 2'(BAD_CODE_SLOW_CYC)) begin
        wdc_edge_reg <= wdc_edge_reg + 2'h1;
      end
    end
  end

  // threshold register: restore on bad-code reset, keep on uv
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      level_reg <= LEVEL_SEL_RESET;
      wdt_code_reg <= WDT_CODE_RESET;
    end else begin
      if (lvl_fire) begin
        level_reg <= LEVEL_SEL_RESET;
      end else if (wr_level) begin
        level_reg <= i_writedata[7:0];
      end
      if (wdc_fire || wdt_full) begin
        wdt_code_reg <= WDT_CODE_RESET;
      end else if (wr_wdt) begin
        wdt_code_reg <= i_writedata[4:0];
      end
    end
  end

  // flags: set wins over software clear
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      uv_flag_reg <= 1'b0;
      lvl_flag_reg <= 1'b0;
      wdc_flag_reg <= 1'b0;
      idle_keep_reg <= 1'b0;
    end else begin
      if (uv_fire) uv_flag_reg <= 1'b1;
      else if (wr_cause && !i_writedata[CAUSE_UV]) uv_flag_reg <= 1'b0;
      if (level_bad) lvl_flag_reg <= 1'b1;
      else if (wr_cause && !i_writedata[CAUSE_LVL]) lvl_flag_reg <= 1'b0;
      if (wdc_fire) wdc_flag_reg <= 1'b1;
      else if (wr_cause && !i_writedata[CAUSE_WDC]) wdc_flag_reg <= 1'b0;
      if (wr_cause) idle_keep_reg <= i_writedata[CAUSE_IDLE_KEEP];
    end
  end

  // status per reset type; power-on clears both
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      expiry_reg <= 1'b0;
      pdown_reg <= 1'b0;
    end else begin
      if (wdt_full || wdt_part) expiry_reg <= 1'b1;
      else if (wr_status) expiry_reg <= i_writedata[STAT_EXPIRY];
      if (wdt_part) pdown_reg <= 1'b1;
      else if (wr_status) pdown_reg <= i_writedata[STAT_PDOWN];
    end
  end

  // synchronous release of combined reset
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      full_rst_reg <= 1'b1;
      pc_sp_rst_reg <= 1'b1;
      por_reg <= 1'b1;
      wdt_on_reg <= 1'b1;
    end else begin
      full_rst_reg <= state_next != ST_RUN;
      pc_sp_rst_reg <= (state_next != ST_RUN) || wdt_part;
      por_reg <= state_reg == ST_POR;
      wdt_on_reg <= wdt_code_reg == WDT_CODE_ON;
    end
  end

  // bus: every access gets exactly one wait state
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
      if (rd_take) rdata_reg <= rd_mux;
    end
  end

  assign o_waitrequest = wait_reg;
  assign o_readdata = rdata_reg;
  assign o_full_rst = full_rst_reg;
  assign o_pc_sp_rst = pc_sp_rst_reg;
  assign o_por_state = por_reg;
  assign o_level_sel = level_reg;
  assign o_wdt_on = wdt_on_reg;

  // checks
  property p_uv_flag;
    @(posedge I_CLK) disable iff (!I_RST_N) uv_fire |=> uv_flag_reg;
  endproperty
  a_uv_flag: assert property (p_uv_flag) else $error("uv flag not set");
  property p_lvl_restore;
    @(posedge I_CLK) disable iff (!I_RST_N) lvl_fire |=> level_reg == LEVEL_SEL_RESET;
  endproperty
  a_lvl_restore: assert property (p_lvl_restore) else $error("level not restored");
  property p_uv_keep;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (uv_fire && !lvl_fire && !wr_level) |=> $stable(level_reg);
  endproperty
  a_uv_keep: assert property (p_uv_keep) else $error("level changed on uv");
  property p_lvl_flag;
    @(posedge I_CLK) disable iff (!I_RST_N) level_bad |=> lvl_flag_reg;
  endproperty
  a_lvl_flag: assert property (p_lvl_flag) else $error("level flag missing");
  property p_no_sw_set;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (!uv_flag_reg && !uv_fire) |=> !uv_flag_reg;
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("uv flag set by sw");
  property p_pdown_no_uv;
    @(posedge I_CLK) disable iff (!I_RST_N) i_powerdown |-> !uv_fire;
  endproperty
  a_pdown_no_uv: assert property (p_pdown_no_uv) else $error("uv in power-down");
  property p_wdt_full;
    @(posedge I_CLK) disable iff (!I_RST_N) wdt_full |=> o_full_rst && expiry_reg;
  endproperty
  a_wdt_full: assert property (p_wdt_full) else $error("wdt full reset missing");
  property p_wdt_part;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (wdt_part && !any_full) |=> o_pc_sp_rst && !o_full_rst && expiry_reg && pdown_reg;
  endproperty
  a_wdt_part: assert property (p_wdt_part) else $error("wdt partial reset wrong");
  property p_release;
    @(posedge I_CLK) disable iff (!I_RST_N) $rose(running) |-> ##[0:1] !o_full_rst;
  endproperty
  a_release: assert property (p_release) else $error("reset not released");
  property p_uv_persist;
    @(posedge I_CLK) disable iff (!I_RST_N) uv_fire |-> $past(lsup_q);
  endproperty
  a_uv_persist: assert property (p_uv_persist) else $error("uv without low supply");
  property p_lvl_fire_bad;
    @(posedge I_CLK) disable iff (!I_RST_N) lvl_fire |-> $past(level_bad);
  endproperty
  a_lvl_fire_bad: assert property (p_lvl_fire_bad) else $error("level reset too early");
  property p_lvl_reset;
    @(posedge I_CLK) disable iff (!I_RST_N) lvl_fire |=> o_full_rst && !running;
  endproperty
  a_lvl_reset: assert property (p_lvl_reset) else $error("no reset on bad level");
  property p_wdc_flag;
    @(posedge I_CLK) disable iff (!I_RST_N) wdc_fire |=> wdc_flag_reg && o_full_rst;
  endproperty
  a_wdc_flag: assert property (p_wdc_flag) else $error("watchdog code flag missing");
  property p_wdc_restore;
    @(posedge I_CLK) disable iff (!I_RST_N) wdc_fire |=> wdt_code_reg == WDT_CODE_RESET;
  endproperty
  a_wdc_restore: assert property (p_wdc_restore) else $error("wdt code not restored");
  property p_uv_status;
    @(posedge I_CLK) disable iff (!I_RST_N) (uv_fire && !wdt_full && !wdt_part && !wr_status)
      |=> $stable(expiry_reg) && $stable(pdown_reg);
  endproperty
  a_uv_status: assert property (p_uv_status) else $error("status changed on uv");
  property p_por_hold;
    @(posedge I_CLK) disable iff (!I_RST_N) state_reg == ST_POR |-> o_full_rst && o_pc_sp_rst;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset released in power-on");
  property p_por_ports;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (state_reg == ST_SETTLE && $past(state_reg) == ST_POR) |-> o_por_state;
  endproperty
  a_por_ports: assert property (p_por_ports) else $error("power-on state missing");
  property p_settle_fast;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (state_reg == ST_SETTLE && count_reg == 32'h0 && i_clk_src == SRC_FAST) |-> ##16 running;
  endproperty
  a_settle_fast: assert property (p_settle_fast) else $error("fast settle wrong");
  property p_settle_xtal;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (state_reg == ST_SETTLE && count_reg == 32'h0 && i_clk_src == SRC_XTAL) |-> ##128 running;
  endproperty
  a_settle_xtal: assert property (p_settle_xtal) else $error("crystal settle wrong");
  property p_flag_clear;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (wr_cause && !i_writedata[CAUSE_UV] && !uv_fire) |=> !uv_flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("uv flag not cleared");
  property p_bus_one_wait;
    @(posedge I_CLK) disable iff (!I_RST_N) (bus_req && o_waitrequest) |=> !o_waitrequest;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus not answered");
  property p_wdt_on;
    @(posedge I_CLK) disable iff (!I_RST_N) (running && wdt_code_reg == WDT_CODE_ON) |=> o_wdt_on;
  endproperty
  a_wdt_on: assert property (p_wdt_on) else $error("watchdog not counting");
  c_uv: cover property (@(posedge I_CLK) disable iff (!I_RST_N) uv_fire);
  c_lvl: cover property (@(posedge I_CLK) disable iff (!I_RST_N) lvl_fire);
  c_wdc: cover property (@(posedge I_CLK) disable iff (!I_RST_N) wdc_fire);
  c_part: cover property (@(posedge I_CLK) disable iff (!I_RST_N) wdt_part);
  c_xtal: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    state_reg == ST_SETTLE && i_clk_src == SRC_XTAL);
endmodule

// ==== hw/rstc_pkg.sv ====
// constants for the reset controller
package rstc_pkg;
  // register byte addresses (word aligned)
  localparam logic [3:0] ADDR_LEVEL_SEL = 4'h0;
  localparam logic [3:0] ADDR_CAUSE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_WDT_EN = 4'hC;
  // threshold codes
  localparam logic [7:0] LVL_2V10 = 8'h55;
  localparam logic [7:0] LVL_2V55 = 8'h33;
  localparam logic [7:0] LVL_3V15 = 8'h99;
  localparam logic [7:0] LVL_3V80 = 8'hAA;
  localparam logic [7:0] LEVEL_SEL_RESET = 8'h55;
  // watchdog enable codes
  localparam logic [4:0] WDT_CODE_ON = 5'h0A;
  localparam logic [4:0] WDT_CODE_OFF = 5'h15;
  localparam logic [4:0] WDT_CODE_RESET = 5'h0A;
  // cause register fields
  localparam int CAUSE_IDLE_KEEP = 7;
  localparam int CAUSE_UV = 2;
  localparam int CAUSE_LVL = 1;
  localparam int CAUSE_WDC = 0;
  // status fields
  localparam int STAT_EXPIRY = 1;
  localparam int STAT_PDOWN = 0;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int POR_DELAY_MS = 50;
  localparam int POR_DELAY_CYC = POR_DELAY_MS * 1000 * CLK_MHZ;
  localparam int BAD_CODE_SLOW_CYC = 2;
  localparam int SETTLE_FAST_CYC = 16;
  localparam int SETTLE_XTAL_CYC = 128;
  localparam int SETTLE_SLOW_CYC = 2;
  // clock source select
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_SLOW = 2'h2;
endpackage

// ==== tb/rstc_core_model.sv ====
// core-side model: slow oscillator source and reset observer
`timescale 1ns/100ps
module rstc_core_model (
  // clock
  input wire logic i_clk,
  // resets from the controller
  input wire logic i_full_rst,
  input wire logic i_pc_sp_rst,
  // slow oscillator and reset counts
  output logic o_slow_osc = 1'b0,
  output int o_full_cnt = 0,
  output int o_pcsp_cnt = 0
);
  logic [2:0] div_reg = 3'h0;
  logic full_d_reg = 1'b1;
  logic pcsp_d_reg = 1'b1;
  // slow clock at one sixteenth of the system clock
  always @(posedge i_clk) begin
    div_reg <= div_reg + 3'h1;
    if (div_reg == 3'h7) begin
      o_slow_osc <= ~o_slow_osc;
    end
    full_d_reg <= i_full_rst;
    pcsp_d_reg <= i_pc_sp_rst;
    // full restart of the core
    if (i_full_rst && !full_d_reg) begin
      o_full_cnt <= o_full_cnt + 1;
    end
    // only pc and stack pointer cleared, rest of the core keeps state
    if (i_pc_sp_rst && !pcsp_d_reg && !i_full_rst) begin
      o_pcsp_cnt <= o_pcsp_cnt + 1;
    end
  end
endmodule

// ==== tb/mcu_reset_controller_test.sv ====
// self-checking bench for the reset controller
`timescale 1ns/100ps
module mcu_reset_controller_test;
  import rstc_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [3:0] i_address = 4'h0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic i_low_supply = 1'b0;
  logic i_slow_osc;
  logic i_wdt_timeout = 1'b0;
  logic i_sleep_mode = 1'b0;
  logic i_powerdown = 1'b0;
  logic [1:0] i_clk_src = SRC_FAST;
  logic o_full_rst;
  logic o_pc_sp_rst;
  logic o_por_state;
  logic o_wdt_on;
  logic [7:0] o_level_sel;
  logic [7:0] codes [4] = '{LVL_2V10, LVL_3V15, LVL_3V80, LVL_2V55};
  int full_cnt;
  int pcsp_cnt;
  int n_fail = 0;
  int n_compared = 0;
  int n;
  int base;
  always #2 I_CLK = ~I_CLK;
  mcu_reset_controller #(.POR_CYC(20), .UV_MIN_CYC(4)) u_mcu_reset_controller (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_low_supply(i_low_supply), .i_slow_osc(i_slow_osc),
    .i_wdt_timeout(i_wdt_timeout), .i_sleep_mode(i_sleep_mode), .i_powerdown(i_powerdown),
    .i_clk_src(i_clk_src), .o_full_rst(o_full_rst), .o_pc_sp_rst(o_pc_sp_rst),
    .o_por_state(o_por_state), .o_level_sel(o_level_sel), .o_wdt_on(o_wdt_on));
  rstc_core_model u_rstc_core_model (.i_clk(I_CLK), .i_full_rst(o_full_rst),
    .i_pc_sp_rst(o_pc_sp_rst), .o_slow_osc(i_slow_osc), .o_full_cnt(full_cnt),
    .o_pcsp_cnt(pcsp_cnt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ack();
    int k;
    k = 0;
    do begin
      @(posedge I_CLK);
      k++;
    end while (o_waitrequest !== 1'b0 && k < 100);
    chk({31'h0, k < 100}, 32'h1, "bus answer");
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_write <= 1'b1;
    ack();
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
    logic [31:0] v;
    @(posedge I_CLK);
    i_address <= a;
    i_read <= 1'b1;
    ack();
    v = o_readdata;
    i_read <= 1'b0;
    chk(v & {24'hFFFFFF, m}, {24'h0, e}, s);
  endtask
  // cycles until the full reset reaches the given level
  task automatic wait_rst(input logic lvl, input int lim, output int c);
    c = 0;
    while (o_full_rst !== lvl && c < lim) begin
      @(posedge I_CLK);
      c++;
    end
    chk({31'h0, o_full_rst}, {31'h0, lvl}, "full reset level");
  endtask
  task automatic low_for(input int len);
    @(posedge I_CLK);
    i_low_supply <= 1'b1;
    repeat (len) @(posedge I_CLK);
    i_low_supply <= 1'b0;
  endtask
  task automatic pulse_wdt();
    @(posedge I_CLK);
    i_wdt_timeout <= 1'b1;
    @(posedge I_CLK);
    i_wdt_timeout <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("compared %0d, wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    chk({31'h0, o_por_state}, 32'h1, "ports held as inputs");
    rd(ADDR_LEVEL_SEL, 8'hFF, LEVEL_SEL_RESET, "level reset");
    rd(ADDR_STATUS, 8'h03, 8'h00, "status after power-on");
    rd(ADDR_CAUSE, 8'h03, 8'h00, "cause after power-on");
    rd(ADDR_WDT_EN, 8'h1F, {3'h0, WDT_CODE_ON}, "watchdog code");
    wait_rst(1'b0, 400, n);
    chk({31'h0, n + 15 inside {[35:42]}}, 32'h1, "power-on hold");
    chk({29'h0, o_por_state, o_pc_sp_rst, o_wdt_on}, 32'h1, "run state");
    $display("test power-on done");
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_CAUSE, 8'h07);
    rd(ADDR_CAUSE, 8'h07, 8'h00, "flags not set by software");
    base = full_cnt;
    foreach (codes[i]) begin
      wr(ADDR_LEVEL_SEL, codes[i]);
      repeat (60) @(posedge I_CLK);
      rd(ADDR_LEVEL_SEL, 8'hFF, codes[i], "valid code kept");
    end
    chk({31'h0, full_cnt == base}, 32'h1, "no reset on valid codes");
    $display("test codes done");
    low_for(2);
    repeat (30) @(posedge I_CLK);
    chk({31'h0, full_cnt == base}, 32'h1, "short dip ignored");
    @(posedge I_CLK);
    i_powerdown <= 1'b1;
    low_for(20);
    repeat (30) @(posedge I_CLK);
    chk({31'h0, full_cnt == base}, 32'h1, "no reset in power-down");
    i_powerdown <= 1'b0;
    low_for(20);
    wait_rst(1'b0, 200, n);
    chk({31'h0, full_cnt == base + 1}, 32'h1, "undervoltage reset");
    rd(ADDR_LEVEL_SEL, 8'hFF, LVL_2V55, "level kept");
    rd(ADDR_CAUSE, 8'h07, 8'h04, "undervoltage flag");
    rd(ADDR_STATUS, 8'h03, 8'h00, "status unchanged");
    $display("test undervoltage done");
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_LEVEL_SEL, 8'h00);
    wait_rst(1'b1, 100, n);
    chk({31'h0, n inside {[16:52]}}, 32'h1, "bad code delay");
    wait_rst(1'b0, 200, n);
    chk({24'h0, o_level_sel}, {24'h0, LEVEL_SEL_RESET}, "level restored");
    rd(ADDR_CAUSE, 8'h07, 8'h02, "level code flag");
    $display("test bad level code done");
    wr(ADDR_CAUSE, 8'h00);
    pulse_wdt();
    wait_rst(1'b1, 20, n);
    wait_rst(1'b0, 200, n);
    rd(ADDR_STATUS, 8'h03, 8'h02, "expiry after normal timeout");
    base = full_cnt;
    n = pcsp_cnt;
    @(posedge I_CLK);
    i_sleep_mode <= 1'b1;
    pulse_wdt();
    repeat (10) @(posedge I_CLK);
    chk({31'h0, pcsp_cnt == n + 1 && full_cnt == base}, 32'h1, "sleep timeout");
    rd(ADDR_STATUS, 8'h03, 8'h03, "flags after sleep timeout");
    i_sleep_mode <= 1'b0;
    i_clk_src <= SRC_XTAL;
    pulse_wdt();
    wait_rst(1'b1, 20, n);
    wait_rst(1'b0, 400, n);
    chk({31'h0, n inside {[126:130]}}, 32'h1, "crystal settle");
    i_clk_src <= SRC_FAST;
    $display("test watchdog timeout done");
    wr(ADDR_WDT_EN, 8'h00);
    wait_rst(1'b1, 100, n);
    chk({31'h0, n inside {[16:52]}}, 32'h1, "bad watchdog code delay");
    wait_rst(1'b0, 200, n);
    rd(ADDR_CAUSE, 8'h07, 8'h01, "watchdog code flag");
    $display("test bad watchdog code done");
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge I_CLK);
    n_fail++;
    wrap_up();
  end
endmodule
